// *** flash_host_pkg.sv ***
// Constants, command types and pin bundle for the sector flash host controller.
// Assumes a 25 MHz system clock and a flash part with a byte-wide asynchronous bus.

package flash_host_pkg;

    // ==========================================================
    // Geometry
    localparam int ADDR_W      = 19;  // Byte address width
    localparam int DATA_W      = 8;   // Data bus width
    localparam int OFFSET_W    = 8;   // Byte within sector
    localparam int SECTOR_W    = ADDR_W - OFFSET_W;  // Sector number width
    localparam int POLL_BIT    = 7;   // Complement status bit
    localparam int TOGGLE_BIT  = 6;   // Alternating status bit
    localparam int PREFIX_LEN  = 3;   // Commands in the lock prefix

    // ==========================================================
    // Timing
    localparam int CLK_KHZ       = 25000;  // System clock rate
    localparam int READ_ACCESS_NS = 90;    // Least time from select to valid data
    localparam int WE_PULSE_NS   = 100;    // Least write strobe low time
    localparam int LOAD_GAP_US   = 150;    // Longest gap between byte loads
    localparam int PROG_CYCLE_MS = 10;     // Sector program cycle time
    localparam int POWER_ON_MS   = 5;      // Wait after power before programming
    localparam int READ_CYC      = (READ_ACCESS_NS * CLK_KHZ + 999999) / 1000000;
    localparam int WE_PULSE_CYC  = (WE_PULSE_NS * CLK_KHZ + 999999) / 1000000;
    localparam int LOAD_GAP_CYC  = (LOAD_GAP_US * CLK_KHZ) / 1000;
    localparam int GAP_MARGIN_CYC = 8;     // Covers cycles from decision to falling edge
    localparam int PROG_CYCLE_CYC = PROG_CYCLE_MS * CLK_KHZ;
    localparam int POWER_ON_CYC  = POWER_ON_MS * CLK_KHZ;
    localparam int TIMEOUT_FACTOR = 4;     // Poll budget in program cycle times
    localparam int TMR_W         = 24;     // Long timer width
    localparam int PHASE_W       = 4;      // Short phase counter width

    // ==========================================================
    // Commands and carriers
    typedef enum logic [1:0] {
        OP_READ    = 2'h0,  // Single byte read
        OP_PROGRAM = 2'h1,  // Load a sector from the byte stream
        OP_LOCK_ON = 2'h2   // Issue the lock prefix alone
    } op_t;

    typedef struct packed {
        op_t                     op;          // Operation
        logic [ADDR_W-1:0]       addr;        // Read address or sector base
        logic                    use_prefix;  // Precede the load with the prefix
    } cmd_t;

    typedef struct packed {
        logic [OFFSET_W-1:0]     offset;      // Byte within the sector
        logic [DATA_W-1:0]       data;        // Byte to load
        logic                    last;        // Final byte of the sector
    } load_byte_t;

    typedef struct packed {
        logic [DATA_W-1:0]       data;        // Read data or final poll data
        logic                    timeout;     // Poll budget ran out
        logic                    gap_lost;    // Stream stalled, load phase ended early
    } resp_t;

    typedef struct packed {
        logic                    chip_select_n;   // Chip select, active low
        logic                    output_gate_n;   // Output gate, active low
        logic                    write_strobe_n;  // Write strobe, active low
        logic [ADDR_W-1:0]       address_lines;   // Address
        logic [DATA_W-1:0]       data_out;        // Data driven to the part
        logic                    data_oe;         // High while the host drives data
    } flash_pins_t;

endpackage

// *** sector_flash_host.sv ***
// Host controller that reads, loads and programs sectors of a byte-wide flash part.
// Assumes the flash pins are wired straight to the part and data_in is synchronous.

`timescale 1ns/1ps

module sector_flash_host #(
    parameter int                                          POWER_ON_CYC_P = flash_host_pkg::POWER_ON_CYC,
    parameter int                                          PROG_CYCLE_CYC_P = flash_host_pkg::PROG_CYCLE_CYC,
    parameter logic [2:0][flash_host_pkg::ADDR_W-1:0]     PREFIX_ADDR = {19'h00003, 19'h00002, 19'h00001},
    parameter logic [2:0][flash_host_pkg::DATA_W-1:0]     PREFIX_DATA = {8'h03, 8'h02, 8'h01}
) (
    input  wire logic                                      clk,
    input  wire logic                                      rst,
    input  wire logic                                      cmd_valid,
    input  wire flash_host_pkg::cmd_t                      cmd,
    output logic                                           cmd_ready,
    input  wire logic                                      byte_valid,
    input  wire flash_host_pkg::load_byte_t                byte_in,
    output logic                                           byte_ready,
    output logic                                           resp_valid,
    output flash_host_pkg::resp_t                          resp,
    output flash_host_pkg::flash_pins_t                    pins,
    input  wire logic [flash_host_pkg::DATA_W-1:0]         data_in
);
    import flash_host_pkg::*;

    // ==========================================================
    // Sequencer states
    typedef enum logic [8:0] {
        S_WAKE     = 9'h001,  // Power-on wait
        S_IDLE     = 9'h002,  // Waiting for a command
        S_RD       = 9'h004,  // Read cycle, select and gate low
        S_WR_SET   = 9'h008,  // Address and data set up, select low
        S_WR_LOW   = 9'h010,  // Write strobe low
        S_WR_REL   = 9'h020,  // Strobe high, data held one cycle
        S_NEXT     = 9'h040,  // Between loads, watching the gap
        S_POLL     = 9'h080,  // Status read of the last loaded byte
        S_POLL_REL = 9'h100   // Bus released between polls
    } state_t;

    // Derived limits
    localparam logic [TMR_W-1:0]   WAKE_LAST  = TMR_W'(POWER_ON_CYC_P - 1);
    localparam logic [TMR_W-1:0]   GAP_LIMIT  = TMR_W'(LOAD_GAP_CYC - GAP_MARGIN_CYC);
    localparam logic [TMR_W-1:0]   POLL_LIMIT = TMR_W'(TIMEOUT_FACTOR * PROG_CYCLE_CYC_P);
    localparam logic [PHASE_W-1:0] READ_LAST  = PHASE_W'(READ_CYC - 1);
    localparam logic [PHASE_W-1:0] WE_LAST    = PHASE_W'(WE_PULSE_CYC - 1);
    localparam logic [1:0]         PREFIX_END = 2'(PREFIX_LEN);

    state_t                 state;       // Current state
    logic [PHASE_W-1:0]     phase;       // Cycles within a bus phase
    logic [TMR_W-1:0]       tmr;         // Wake, gap and poll timer
    logic [SECTOR_W-1:0]    sector;      // Sector being loaded
    logic [ADDR_W-1:0]      last_addr;   // Address of the last load
    logic [DATA_W-1:0]      last_data;   // Data of the last load
    logic                   last_flag;   // Last load closed the sector
    logic                   with_prefix; // Prefix goes ahead of the bytes
    logic                   only_prefix; // No bytes follow the prefix
    logic [1:0]             prefix_idx;  // Prefix commands already issued
    logic                   any_loaded;  // At least one load was made
    logic                   gap_lost;    // Stream stalled close to the gap budget
    logic [DATA_W-1:0]      poll_data;   // Latest poll sample
    logic                   prev6;       // Alternating bit of the sample before
    logic [1:0]             poll_count;  // Samples taken, saturating at two

    // ==========================================================
    // Decode
    wire logic              cmd_take     = (state == S_IDLE) && cmd_valid && cmd_ready;
    wire logic              prefix_pend  = with_prefix && (prefix_idx != PREFIX_END);
    wire logic              in_next      = (state == S_NEXT);
    wire logic              take_prefix  = in_next && prefix_pend;
    wire logic              take_byte    = in_next && !prefix_pend && !only_prefix
                                           && byte_valid && byte_ready;
    // End of loading: lock alone, or stall close to the gap budget
    wire logic              gap_over     = in_next && !prefix_pend && !take_byte
                                           && (only_prefix || (tmr >= GAP_LIMIT));
    wire logic              load_start   = take_prefix || take_byte;
    // Sector from the upper lines, byte offset from the lower ones
    wire logic [ADDR_W-1:0] byte_addr    = {sector, byte_in.offset};
    wire logic [ADDR_W-1:0] load_addr    = take_prefix ? PREFIX_ADDR[prefix_idx] : byte_addr;
    wire logic [DATA_W-1:0] load_data    = take_prefix ? PREFIX_DATA[prefix_idx] : byte_in.data;
    // Done when bit 7 shows true data and bit 6 stops alternating
    wire logic              poll_done    = (poll_count == 2'h2)
                                           && (poll_data[POLL_BIT] == last_data[POLL_BIT])
                                           && (poll_data[TOGGLE_BIT] == prev6);
    wire logic              poll_expired = tmr >= POLL_LIMIT;
    wire logic              read_end     = (phase == READ_LAST);
    wire logic              we_end       = (phase == WE_LAST);
    wire logic              ready_next   = in_next && !prefix_pend && !only_prefix
                                           && !take_byte && !gap_over;

    // ==========================================================
    // Sequencer and pin drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state          <= S_WAKE;
            phase          <= '0;
            tmr            <= '0;
            cmd_ready      <= 1'b0;
            byte_ready     <= 1'b0;
            resp_valid     <= 1'b0;
            resp           <= '0;
            pins           <= '{chip_select_n: 1'b1, output_gate_n: 1'b1,
                                write_strobe_n: 1'b1, default: '0};
            sector         <= '0;
            last_addr      <= '0;
            last_data      <= '0;
            last_flag      <= 1'b0;
            with_prefix    <= 1'b0;
            only_prefix    <= 1'b0;
            prefix_idx     <= '0;
            any_loaded     <= 1'b0;
            gap_lost       <= 1'b0;
            poll_data      <= '0;
            prev6          <= 1'b0;
            poll_count     <= '0;
        end else begin
            resp_valid <= 1'b0;
            byte_ready <= ready_next;
            phase      <= phase + PHASE_W'(1);
            tmr        <= tmr + TMR_W'(1);
            unique case (state)
                // Hold off all access until the part may program
                S_WAKE: begin
                    if (tmr == WAKE_LAST) begin
                        state     <= S_IDLE;
                        cmd_ready <= 1'b1;
                    end
                end
                // Accept a command
                S_IDLE: begin
                    if (cmd_take) begin
                        cmd_ready <= 1'b0;
                        phase     <= '0;
                        tmr       <= '0;
                        if (cmd.op == OP_READ) begin
                            // Gate low with strobe high reads the array
                            pins.address_lines <= cmd.addr;
                            pins.chip_select_n <= 1'b0;
                            pins.output_gate_n <= 1'b0;
                            state              <= S_RD;
                        end else begin
                            // Lock alone, a plain load, or prefix ahead of a locked load
                            sector      <= cmd.addr[ADDR_W-1:OFFSET_W];
                            with_prefix <= cmd.use_prefix || (cmd.op == OP_LOCK_ON);
                            only_prefix <= (cmd.op == OP_LOCK_ON);
                            prefix_idx  <= '0;
                            any_loaded  <= 1'b0;
                            gap_lost    <= 1'b0;
                            state       <= S_NEXT;
                        end
                    end
                end
                // Read: sample at the end of the access time
                S_RD: begin
                    if (read_end) begin
                        resp_valid         <= 1'b1;
                        resp               <= '{data: data_in, default: 1'b0};
                        pins.chip_select_n <= 1'b1;
                        pins.output_gate_n <= 1'b1;
                        cmd_ready          <= 1'b1;
                        state              <= S_IDLE;
                    end
                end
                // Pick the next load or end the load phase
                S_NEXT: begin
                    if (load_start) begin
                        // Output gate stays high through the whole load
                        pins.address_lines <= load_addr;
                        pins.data_out      <= load_data;
                        pins.data_oe       <= 1'b1;
                        pins.chip_select_n <= 1'b0;
                        last_addr          <= load_addr;
                        last_data          <= load_data;
                        last_flag          <= take_byte && byte_in.last;
                        any_loaded         <= 1'b1;
                        prefix_idx         <= take_prefix ? prefix_idx + 2'h1 : prefix_idx;
                        state              <= S_WR_SET;
                    end else if (gap_over) begin
                        gap_lost <= !only_prefix;
                        phase    <= '0;
                        tmr      <= '0;
                        if (any_loaded) begin
                            // Part now programs on its own timer; poll it
                            pins.address_lines <= last_addr;
                            pins.chip_select_n <= 1'b0;
                            pins.output_gate_n <= 1'b0;
                            poll_count         <= '0;
                            state              <= S_POLL;
                        end else begin
                            resp_valid <= 1'b1;
                            resp       <= '{data: '0, timeout: 1'b0, gap_lost: 1'b1};
                            cmd_ready  <= 1'b1;
                            state      <= S_IDLE;
                        end
                    end
                end
                // Address settled; strobe falls last so it latches it
                S_WR_SET: begin
                    pins.write_strobe_n <= 1'b0;
                    phase               <= '0;
                    state               <= S_WR_LOW;
                end
                // Strobe low long enough to pass the noise filter
                S_WR_LOW: begin
                    if (we_end) begin
                        pins.write_strobe_n <= 1'b1;
                        state               <= S_WR_REL;
                    end
                end
                // Data held one cycle past the strobe rise
                S_WR_REL: begin
                    pins.chip_select_n <= 1'b1;
                    pins.data_oe       <= 1'b0;
                    phase              <= '0;
                    tmr                <= '0;
                    if (last_flag) begin
                        // Fresh poll count, else a count left from the last poll ends it at once
                        poll_count <= '0;
                        state      <= S_POLL_REL;
                    end else begin
                        state <= S_NEXT;
                    end
                end
                // Status read of the last loaded location
                S_POLL: begin
                    if (read_end) begin
                        poll_data          <= data_in;
                        prev6              <= poll_data[TOGGLE_BIT];
                        poll_count         <= (poll_count == 2'h2) ? poll_count
                                                                   : poll_count + 2'h1;
                        pins.chip_select_n <= 1'b1;
                        pins.output_gate_n <= 1'b1;
                        state              <= S_POLL_REL;
                    end
                end
                // Judge the sample; new access only after completion
                S_POLL_REL: begin
                    phase <= '0;
                    if (poll_done || poll_expired) begin
                        resp_valid <= 1'b1;
                        resp       <= '{data: poll_data, timeout: !poll_done,
                                        gap_lost: gap_lost};
                        cmd_ready  <= 1'b1;
                        state      <= S_IDLE;
                    end else begin
                        pins.address_lines <= last_addr;
                        pins.chip_select_n <= 1'b0;
                        pins.output_gate_n <= 1'b0;
                        if (last_flag && (poll_count == 2'h0) && (phase == '0)) begin
                            poll_count <= '0;
                            tmr        <= '0;
                        end
                        state <= S_POLL;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// *** sector_flash_host_properties.sv ***
// Checker for the sector flash host controller ports.
// Assumes the default 3-cycle strobe and read timing of the package.
`timescale 1ns/1ps
module sector_flash_host_properties
    import flash_host_pkg::*;
#(
    parameter int POWER_ON_CYC_P   = POWER_ON_CYC,
    parameter int PROG_CYCLE_CYC_P = PROG_CYCLE_CYC
) (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                cmd_valid,
    input wire cmd_t                cmd,
    input wire logic                cmd_ready,
    input wire logic                byte_valid,
    input wire load_byte_t          byte_in,
    input wire logic                byte_ready,
    input wire logic                resp_valid,
    input wire resp_t               resp,
    input wire flash_pins_t         pins,
    input wire logic [DATA_W-1:0]   data_in
);
    // ==========================================
    // Helpers
    localparam int GAP_MAX = LOAD_GAP_CYC;  // Longest gap between loads in cycles
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic        loading;                   // Strobe seen since the last answer
    logic [12:0] gap;                       // Cycles since the strobe was last low
    wire take    = cmd_valid && cmd_ready;  // Command taken
    wire rd_take = take && cmd.op == OP_READ;
    // Gap counter saturates so a long idle never wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loading <= 1'b0;
            gap     <= '0;
        end else begin
            loading <= !pins.write_strobe_n ? 1'b1 : (resp_valid ? 1'b0 : loading);
            gap     <= !pins.write_strobe_n ? '0 : gap + 13'(gap != 13'h1fff);
        end
    end
    // ==========================================
    // Assertions
    a_gate_in_write :
    assert property ((!pins.write_strobe_n || pins.data_oe) |-> pins.output_gate_n)
        else $error("output gate low while writing");
    a_strobe_select :
    assert property ($fell(pins.write_strobe_n) |-> !$past(pins.chip_select_n))
        else $error("strobe fell without select");
    a_strobe_width :
    assert property ($fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*3] ##1 pins.write_strobe_n)
        else $error("strobe pulse width wrong");
    a_write_hold :
    assert property (!pins.write_strobe_n |=> $stable(pins.address_lines) && $stable(pins.data_out))
        else $error("address or data moved in a write");
    a_read_pins :
    assert property (rd_take |=> !pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n
                     && !pins.data_oe && pins.address_lines == $past(cmd.addr))
        else $error("read pins wrong");
    a_read_answer :
    assert property (rd_take |-> ##4 resp_valid && resp.data == $past(data_in))
        else $error("read answer wrong");
    a_cmd_busy :
    assert property (take |=> !cmd_ready [*3])
        else $error("command accepted while busy");
    a_ready_resp :
    assert property (resp_valid |-> cmd_ready)
        else $error("not ready at answer");
    a_load_gap :
    assert property ($fell(pins.write_strobe_n) && loading |-> gap < GAP_MAX)
        else $error("load gap too long");
    c_read : cover property (rd_take);
    c_prog : cover property (take && cmd.op == OP_PROGRAM && cmd.use_prefix);
    c_lock : cover property (take && cmd.op == OP_LOCK_ON);
    c_stall : cover property (resp_valid && resp.gap_lost);
endmodule

bind sector_flash_host sector_flash_host_properties #(
    .POWER_ON_CYC_P(POWER_ON_CYC_P),
    .PROG_CYCLE_CYC_P(PROG_CYCLE_CYC_P)
) chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
       .byte_valid(byte_valid), .byte_in(byte_in), .byte_ready(byte_ready),
       .resp_valid(resp_valid), .resp(resp), .pins(pins), .data_in(data_in));

// *** flash_model.sv ***
// Behavioural byte-wide sector flash part.
// Assumes a host that keeps the gate high while loading.
`timescale 1ns/1ps
module flash_model #(
    parameter real              PROG_NS = 40000.0,  // Shortened program cycle
    parameter real              WAKE_NS = 200.0,    // Shortened power-on delay
    parameter logic [2:0][18:0] PFX_A   = {19'h00003, 19'h00002, 19'h00001},
    parameter logic [2:0][7:0]  PFX_D   = {8'h03, 8'h02, 8'h01}
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dout
);
    logic [7:0]  mem [logic [18:0]];  // Written bytes, others a pattern
    logic [26:0] loads [$];           // Loaded address and data in order
    logic [18:0] lat_a;               // Address from the later fall
    logic [7:0]  last_d;              // Last loaded byte
    logic        lock = 1'b0;         // Write lock, off when shipped
    logic        busy = 1'b0;         // Load phase or program running
    logic        tgl = 1'b0;          // Alternating status bit
    logic        armed = 1'b0;        // Fall seen, waiting for rise
    logic        pfx;                 // Load began with the lock prefix
    realtime     t_fall, t_rise;
    initial dout = 8'h00;
    // Address on the later fall, only with the gate high
    always @(negedge ce_n or negedge we_n) if (!ce_n && !we_n && oe_n) begin
        lat_a  = addr;
        t_fall = $realtime;
        armed  = 1'b1;
    end
    // Data on the first rise; glitches start nothing
    always @(posedge ce_n or posedge we_n) if (armed) begin
        armed = 1'b0;
        if ($realtime - t_fall >= 15.0 && $realtime >= WAKE_NS) begin
            loads.push_back({lat_a, din});
            last_d = din;
            busy   = 1'b1;
            t_rise = $realtime;
        end
    end
    // Quiet for 150 us ends loading; erase and program on own timer
    always #1000 if (!armed && loads.size() > 0 && $realtime - t_rise >= 150000.0) begin
        pfx = loads.size() >= 3;
        if (pfx) for (int i = 0; i < 3; i++) if (loads[i] != {PFX_A[i], PFX_D[i]}) pfx = 1'b0;
        if (pfx) begin
            lock = 1'b1;
            repeat (3) void'(loads.pop_front());
        end
        if (pfx || !lock) begin  // Locked without prefix writes nothing
            if (loads.size() > 0) for (int i = 0; i < 256; i++) mem[{loads[0][26:16], 8'(i)}] = 8'hff;
            foreach (loads[i]) mem[loads[i][26:8]] = loads[i][7:0];
        end
        loads.delete();
        #(PROG_NS) busy = 1'b0;
    end
    // Status alternates on each read while busy
    always @(negedge oe_n) if (busy) tgl = ~tgl;
    // Array or status read; released lines show the inverse
    always @(ce_n, oe_n, we_n, addr, busy, tgl) begin
        if (!ce_n && !oe_n && we_n)
            dout = busy ? {~last_d[7], tgl, last_d[5:0]}
                        : (mem.exists(addr) ? mem[addr] : addr[7:0] ^ 8'h5a);
        else
            dout = ~dout;
    end
endmodule

// *** test_sector_flash_host.sv ***
// Self-checking bench for the sector flash host controller.
// Assumes the behavioural flash part on the far side of the pins.
`timescale 1ns/1ps
module test_sector_flash_host;
    import flash_host_pkg::*;
    logic        clk = 0, rst = 1, cmd_valid = 0, byte_valid = 0, cmd_ready, byte_ready, resp_valid;
    cmd_t        cmd = '0;
    load_byte_t  byte_in = '0;
    resp_t       resp;
    flash_pins_t pins;
    logic [7:0]  data_in;
    int          fail_count = 0, checks_done = 0;
    resp_t       exp_q [$];                               // Expected answers in order
    logic [18:0] sa;                                      // Sector under test
    logic [7:0]  d [4];                                   // Random sector data
    logic [7:0]  offs [4] = '{8'h00, 8'hff, 8'h37, 8'h80};  // Out-of-order offsets
    // ==========================================
    // Design and far side
    sector_flash_host #(.POWER_ON_CYC_P(4), .PROG_CYCLE_CYC_P(2000)) uut (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .byte_valid(byte_valid), .byte_in(byte_in), .byte_ready(byte_ready),
        .resp_valid(resp_valid), .resp(resp), .pins(pins), .data_in(data_in));
    flash_model far (.ce_n(pins.chip_select_n), .oe_n(pins.output_gate_n),
        .we_n(pins.write_strobe_n), .addr(pins.address_lines), .din(pins.data_out), .dout(data_in));
    initial forever #20 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input op_t op, input logic [18:0] a, input logic p, input resp_t e);
        @(negedge clk);
        cmd_valid = 1;
        cmd = '{op, a, p};
        exp_q.push_back(e);
        for (int i = 0; i < 20000 && cmd_ready !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
    endtask
    task automatic put(input logic [7:0] o, input logic [7:0] v, input logic l);
        @(negedge clk);
        byte_valid = 1;
        byte_in = '{o, v, l};
        for (int i = 0; i < 20000 && byte_ready !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        byte_valid = 0;
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] e);
        issue(OP_READ, a, 1'b0, '{e, 1'b0, 1'b0});
    endtask
    // Four bytes out of order, last one closes the load phase
    task automatic prog(input logic p, input logic [7:0] x, input logic [7:0] e);
        issue(OP_PROGRAM, sa, p, '{e, 1'b0, 1'b0});
        for (int i = 0; i < 4; i++) put(offs[i], d[i] ^ x, i == 3);
    endtask
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Compare each answer with the oldest note
    always @(negedge clk) if (!rst && resp_valid === 1'b1) begin
        if (exp_q.size() == 0) check(1, 0, "unexpected answer");
        else check(32'(resp), 32'(exp_q.pop_front()), "answer");
    end
    // ==========================================
    // Scenarios
    initial begin
        void'($urandom(32'h5cea));
        sa = {11'($urandom_range(2046, 1)), 8'h00};
        foreach (d[i]) d[i] = 8'($urandom);
        repeat (2) @(negedge clk);
        rst = 0;
        rd(sa | 19'h37, 8'h37 ^ 8'h5a);
        prog(1'b0, 8'h00, d[3]);
        for (int i = 0; i < 4; i++) rd(sa | 19'(offs[i]), d[i]);
        rd(sa | 19'h01, 8'hff);
        issue(OP_LOCK_ON, 19'h0, 1'b0, '{8'h59, 1'b0, 1'b0});
        prog(1'b0, 8'h7f, d[3]);
        rd(sa, d[0]);
        prog(1'b1, 8'h0f, d[3] ^ 8'h0f);
        rd(sa | 19'hff, d[1] ^ 8'h0f);
        issue(OP_PROGRAM, sa, 1'b0, '{8'h00, 1'b0, 1'b1});
        for (int i = 0; i < 20000 && exp_q.size() > 0; i++) @(negedge clk);
        check(exp_q.size(), 0, "answers left");
        conclude();
    end
    // Watchdog well beyond four program cycles
    initial begin
        #2000000;
        fail_count++;
        conclude();
    end
endmodule
